// File: hw/hszc_defs.svh
// Constants of the high speed zone compare block
`ifndef HSZC_DEFS_SVH
`define HSZC_DEFS_SVH

// ------------------------------------------------------------
// Counts and widths
// ------------------------------------------------------------
`define HSZC_SW_SLOTS       6
`define HSZC_HW_GROUPS      2
`define HSZC_SLOTS          8
`define HSZC_GRP_COMPS      4
`define HSZC_CNT_W          32
`define HSZC_CNT_ID_W       4

// ------------------------------------------------------------
// Counter identities and comparator masks
// ------------------------------------------------------------
`define HSZC_FIRST_SW_CNT   4'h0
`define HSZC_PAIR_FULL      4'hc
`define HSZC_PAIR_REDUCED   4'h3
`define HSZC_AVAIL_FULL     4'hf
`define HSZC_AVAIL_REDUCED  4'h3

// ------------------------------------------------------------
// Result codes and reset values
// ------------------------------------------------------------
`define HSZC_RES_RST        3'h0
`define HSZC_RES_BELOW      3'h1
`define HSZC_RES_WITHIN     3'h2
`define HSZC_RES_ABOVE      3'h4
`define HSZC_MASK_RST       4'h0
`define HSZC_SLOT_RST       6'h00

`endif

// File: hw/hszc_pkg.sv
// Types shared by the high speed zone compare block
`default_nettype none

package hszc_pkg;

  // Destination class of the three result devices
  typedef enum logic [1:0] {
    hszc_kind_fast  = 2'h0,
    hszc_kind_relay = 2'h1,
    hszc_kind_slow  = 2'h2
  } hszc_kind_t;

endpackage

`default_nettype wire

// File: hw/hszc_zone.sv
// One zone comparator with three result devices
`include "hszc_defs.svh"
`default_nettype none

module hszc_zone (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_ce,
  input  wire logic                           i_en,
  input  wire logic signed [`HSZC_CNT_W-1:0]  i_count,
  input  wire logic signed [`HSZC_CNT_W-1:0]  i_lower,
  input  wire logic signed [`HSZC_CNT_W-1:0]  i_upper,
  input  wire logic [1:0]                     i_kind,
  input  wire logic                           i_scan_end,
  output logic [2:0]                          o_res,
  output logic                                o_bound_err
);

  typedef struct packed {
    logic [2:0] res;
    logic       bound_err;
  } hszc_zone_st_t;

  hszc_zone_st_t st;
  hszc_zone_st_t next_st;
  logic [2:0]    zone_val;
  logic          immediate;

  // ------------------------------------------------------------
  // Compare and update
  // ------------------------------------------------------------
  always_comb begin
    next_st   = st;
    immediate = (i_kind != hszc_pkg::hszc_kind_slow);
    if (i_count <= i_lower) begin
      zone_val = `HSZC_RES_BELOW;
    end else if (i_count <= i_upper) begin
      zone_val = `HSZC_RES_WITHIN;
    end else begin
      zone_val = `HSZC_RES_ABOVE;
    end
    // Bad bounds give no result rather than a wrong one
    next_st.bound_err = i_en && (i_lower > i_upper);
    if (!i_en || next_st.bound_err) begin
      next_st.res = `HSZC_RES_RST;
    end else if (immediate || i_scan_end) begin
      // Fast and relay kinds update every cycle; the slow kind only on i_scan_end
      next_st.res = zone_val;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '{res: `HSZC_RES_RST, bound_err: 1'b0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_res       = st.res;
  assign o_bound_err = st.bound_err;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n || !i_ce);

  sequence fast_req;
    i_en && (i_lower <= i_upper) && immediate;
  endsequence

  one_hot_res_a: assert property ((o_res != 3'h0) |-> $onehot(o_res))
    else $error("zone result not one-hot");
  release_clear_a: assert property (!i_en |=> o_res == 3'h0)
    else $error("result not cleared after release");
  lower_hit_a: assert property (fast_req and (i_count <= i_lower)
      |=> o_res == `HSZC_RES_BELOW)
    else $error("count at lower bound not below");
  fast_update_a: assert property (fast_req |=> o_res == $past(zone_val))
    else $error("immediate result late");
  slow_hold_a: assert property ((i_en && !immediate && !i_scan_end
      && (i_lower <= i_upper)) |=> $stable(o_res))
    else $error("slow result changed before scan end");
  bound_chk_a: assert property ((i_en && (i_lower > i_upper))
      |=> o_bound_err && (o_res == 3'h0))
    else $error("bad bounds not flagged");

endmodule

`default_nettype wire

// File: hw/hszc_alloc.sv
// Hardware comparator allocation for one counter group
`include "hszc_defs.svh"
`default_nettype none

module hszc_alloc (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_ce,
  input  wire logic       i_reduced,
  input  wire logic       i_zone_req,
  input  wire logic [3:0] i_point_req,
  output logic            o_zone_grant,
  output logic            o_zone_err,
  output logic [3:0]      o_point_grant,
  output logic [3:0]      o_point_err
);

  typedef struct packed {
    logic       zone_hold;
    logic       zone_err;
    logic [3:0] point_hold;
    logic [3:0] point_err;
  } hszc_alloc_st_t;

  hszc_alloc_st_t st;
  hszc_alloc_st_t next_st;
  logic [3:0]     pair;
  logic [3:0]     avail;
  logic [3:0]     pt_new;
  logic           zone_ok;

  // ------------------------------------------------------------
  // Claim logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    pair  = i_reduced ? `HSZC_PAIR_REDUCED : `HSZC_PAIR_FULL;
    avail = i_reduced ? `HSZC_AVAIL_REDUCED : `HSZC_AVAIL_FULL;
    // A held pair keeps point compares off it
    pt_new = i_point_req & ~st.point_hold & avail
             & ~(st.zone_hold ? pair : `HSZC_MASK_RST);
    // Absent comparators drop any point hold left from the full variant
    next_st.point_hold = ((i_point_req & st.point_hold) | pt_new)
                         & avail;
    // Same-cycle tie goes to the point compare
    zone_ok = i_zone_req && (st.zone_hold
              || ((next_st.point_hold & pair) == `HSZC_MASK_RST));
    next_st.zone_hold = zone_ok;
    next_st.zone_err  = i_zone_req && !zone_ok;
    next_st.point_err = i_point_req & ~next_st.point_hold;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '{zone_hold: 1'b0, zone_err: 1'b0,
              point_hold: `HSZC_MASK_RST, point_err: `HSZC_MASK_RST};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_zone_grant  = st.zone_hold;
  assign o_zone_err    = st.zone_err;
  assign o_point_grant = st.point_hold;
  assign o_point_err   = st.point_err;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n || !i_ce);

  sequence zone_holding;
    st.zone_hold && i_zone_req && !i_reduced;
  endsequence

  pair_excl_a: assert property (!(st.zone_hold
      && ((st.point_hold & pair) != 4'h0)))
    else $error("zone and point share a comparator");
  point_blocks_a: assert property ((((st.point_hold & i_point_req & pair)
      != 4'h0) && i_zone_req && !st.zone_hold) |=> o_zone_err)
    else $error("zone claim not refused");
  later_error_a: assert property ((zone_holding and
      (i_point_req[3] && !st.point_hold[3])) |=> o_point_err[3])
    else $error("later point claim not flagged");
  reduced_avail_a: assert property (i_reduced |=>
      ((o_point_grant & 4'hc) == 4'h0))
    else $error("absent comparator granted");

endmodule

`default_nettype wire

// File: hw/hszc_top.sv
// High speed zone compare: software slots and hardware groups
`include "hszc_defs.svh"
`default_nettype none

module hszc_top (
  // Clock, reset and enable
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_ce,
  // Variant strap pin, high on the reduced variant
  input  wire logic                        i_reduced_strap,
  // One-cycle pulse at the end of each program scan
  input  wire logic                        i_scan_end,
  // Software zone slots
  input  wire logic [`HSZC_SW_SLOTS-1:0]   i_sw_en,
  input  wire logic [`HSZC_SW_SLOTS-1:0][`HSZC_CNT_ID_W-1:0] i_sw_counter,
  input  wire logic [`HSZC_SW_SLOTS-1:0][`HSZC_CNT_W-1:0]    i_sw_count,
  input  wire logic [`HSZC_SW_SLOTS-1:0][`HSZC_CNT_W-1:0]    i_sw_lower,
  input  wire logic [`HSZC_SW_SLOTS-1:0][`HSZC_CNT_W-1:0]    i_sw_upper,
  input  wire logic [`HSZC_SW_SLOTS-1:0][1:0]                i_sw_kind,
  // Hardware groups
  input  wire logic [`HSZC_HW_GROUPS-1:0]  i_hw_zone_req,
  input  wire logic [`HSZC_HW_GROUPS-1:0][`HSZC_CNT_W-1:0]   i_hw_count,
  input  wire logic [`HSZC_HW_GROUPS-1:0][`HSZC_CNT_W-1:0]   i_hw_lower,
  input  wire logic [`HSZC_HW_GROUPS-1:0][`HSZC_CNT_W-1:0]   i_hw_upper,
  input  wire logic [`HSZC_HW_GROUPS-1:0][1:0]               i_hw_kind,
  input  wire logic [`HSZC_HW_GROUPS-1:0][3:0]               i_point_req,
  // Results: slots 0..5 software, 6..7 hardware groups
  output logic [`HSZC_SLOTS-1:0][2:0]      o_res,
  output logic [`HSZC_SLOTS-1:0]           o_bound_err,
  output logic [`HSZC_SW_SLOTS-1:0]        o_sw_cnt_err,
  output logic [`HSZC_HW_GROUPS-1:0]       o_zone_grant,
  output logic [`HSZC_HW_GROUPS-1:0]       o_zone_err,
  output logic [`HSZC_HW_GROUPS-1:0][3:0]  o_point_grant,
  output logic [`HSZC_HW_GROUPS-1:0][3:0]  o_point_err,
  output logic                             o_reduced
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic                      strap_s1;
    logic                      strap_s2;
    logic                      reduced;
    logic [`HSZC_SW_SLOTS-1:0] cnt_err;
  } hszc_top_st_t;

  hszc_top_st_t st;
  hszc_top_st_t next_st;

  // Per-slot wiring into the comparator array
  logic [`HSZC_SLOTS-1:0]                  slot_en;
  logic [`HSZC_SLOTS-1:0][`HSZC_CNT_W-1:0] slot_count;
  logic [`HSZC_SLOTS-1:0][`HSZC_CNT_W-1:0] slot_lower;
  logic [`HSZC_SLOTS-1:0][`HSZC_CNT_W-1:0] slot_upper;
  logic [`HSZC_SLOTS-1:0][1:0]             slot_kind;
  logic [`HSZC_SW_SLOTS-1:0]               first_hit;

  // ------------------------------------------------------------
  // Strap capture and counter checks
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Strap is a pin, so it is synchronised before use
    next_st.strap_s1 = i_reduced_strap;
    next_st.strap_s2 = st.strap_s1;
    next_st.reduced  = st.strap_s2;
    for (int i = 0; i < `HSZC_SW_SLOTS; i++) begin
      first_hit[i] = st.reduced
                     && (i_sw_counter[i] == `HSZC_FIRST_SW_CNT);
    end
    next_st.cnt_err = i_sw_en & first_hit;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '{strap_s1: 1'b0, strap_s2: 1'b0, reduced: 1'b0,
              cnt_err: `HSZC_SLOT_RST};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_reduced    = st.reduced;
  assign o_sw_cnt_err = st.cnt_err;

  // ------------------------------------------------------------
  // Slot wiring
  // ------------------------------------------------------------
  // Software slots are dedicated to zone compare, so point
  // compares never consume them.
  always_comb begin
    for (int i = 0; i < `HSZC_SW_SLOTS; i++) begin
      slot_en[i]    = i_sw_en[i] && !first_hit[i];
      slot_count[i] = i_sw_count[i];
      slot_lower[i] = i_sw_lower[i];
      slot_upper[i] = i_sw_upper[i];
      slot_kind[i]  = i_sw_kind[i];
    end
    for (int g = 0; g < `HSZC_HW_GROUPS; g++) begin
      // A hardware zone runs only once its pair is granted
      slot_en[`HSZC_SW_SLOTS+g]    = i_hw_zone_req[g]
                                     && o_zone_grant[g];
      slot_count[`HSZC_SW_SLOTS+g] = i_hw_count[g];
      slot_lower[`HSZC_SW_SLOTS+g] = i_hw_lower[g];
      slot_upper[`HSZC_SW_SLOTS+g] = i_hw_upper[g];
      slot_kind[`HSZC_SW_SLOTS+g]  = i_hw_kind[g];
    end
  end

  // ------------------------------------------------------------
  // Zone comparators
  // ------------------------------------------------------------
  // Each slot drives three adjacent result bits as one unit.
  genvar s;
  generate
    for (s = 0; s < `HSZC_SLOTS; s++) begin : g_zone
      hszc_zone u_zone (
        .i_clk_sys   (i_clk_sys),
        .i_reset_n   (i_reset_n),
        .i_ce        (i_ce),
        .i_en        (slot_en[s]),
        .i_count     (slot_count[s]),
        .i_lower     (slot_lower[s]),
        .i_upper     (slot_upper[s]),
        .i_kind      (slot_kind[s]),
        .i_scan_end  (i_scan_end),
        .o_res       (o_res[s]),
        .o_bound_err (o_bound_err[s])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Hardware comparator groups
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `HSZC_HW_GROUPS; g++) begin : g_group
      hszc_alloc u_alloc (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_ce          (i_ce),
        .i_reduced     (st.reduced),
        .i_zone_req    (i_hw_zone_req[g]),
        .i_point_req   (i_point_req[g]),
        .o_zone_grant  (o_zone_grant[g]),
        .o_zone_err    (o_zone_err[g]),
        .o_point_grant (o_point_grant[g]),
        .o_point_err   (o_point_err[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n || !i_ce);

  sequence first_cnt_req;
    st.reduced && i_sw_en[0]
    && (i_sw_counter[0] == `HSZC_FIRST_SW_CNT);
  endsequence

  first_cnt_a: assert property (first_cnt_req
      |=> o_sw_cnt_err[0] && (o_res[0] == 3'h0))
    else $error("first software counter accepted");

  sequence hw_claim;
    i_hw_zone_req[0] && !o_zone_grant[0] && !st.reduced
    && (i_point_req[0] == 4'h0) && (o_point_grant[0] == 4'h0);
  endsequence

  hw_grant_a: assert property ((hw_claim ##1 i_hw_zone_req[0])
      |-> o_zone_grant[0])
    else $error("free zone pair not granted");

  hw_gate_a: assert property (!o_zone_grant[1] |=> o_res[7] == 3'h0)
    else $error("hardware zone ran without grant");

  strap_sync_a: assert property ($rose(i_reduced_strap)
      ##1 i_reduced_strap ##1 i_reduced_strap |=> o_reduced)
    else $error("strap not taken after three edges");

endmodule

`default_nettype wire

// File: tb/hszc_cnt_model.sv
// Behavioural high speed counters that feed the zone comparator
`default_nettype none

module hszc_cnt_model (
  input  wire logic               i_clk_sys,
  input  wire logic               i_load,
  input  wire logic signed [31:0] i_value,
  input  wire logic signed [31:0] i_step,
  output logic [7:0][31:0]        o_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // Counting
  // ----------------------------------------------------------
  // Counter k moves by the signed multiple (k - 3) of the step, so
  // counter 3 stands still and the others sweep the zone at -3 to +4 steps.
  always @(posedge i_clk_sys) begin
    for (int k = 0; k < 8; k++) begin
      if (i_load)
        o_count[k] <= i_value;
      else
        o_count[k] <= o_count[k] + i_step * (k - 3);
    end
  end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench of the high speed zone compare block
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ce = 1'b1;
  logic                  strap = 1'b0;
  logic                  scan = 1'b0;
  logic                  load = 1'b1;
  logic                  chk = 1'b1;
  logic [31:0]           val = 32'h0;
  logic [31:0]           step = 32'h0;
  logic [5:0]            sw_en = 6'h00;
  logic [5:0][3:0]       sw_id = '0;
  logic [5:0][31:0]      sw_lo = {6{32'hffffffce}};
  logic [5:0][31:0]      sw_hi = {6{32'h32}};
  logic [5:0][1:0]       sw_kind = {2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
  logic [1:0]            hz_req = 2'h0;
  logic [1:0][3:0]       pt_req = '0;
  wire  [7:0][31:0]      cnt;
  logic [7:0][2:0]       res;
  logic [7:0]            berr;
  logic [5:0]            cerr;
  logic [1:0]            zg;
  logic [1:0]            ze;
  logic [1:0][3:0]       pg;
  logic [1:0][3:0]       pe;
  logic                  red;
  logic [5:0][2:0]       exp_res;
  logic [5:0]            exp_berr;
  logic [5:0]            exp_cerr;
  int                    lo, hi, c, cyc, error_cnt, tests_run;
  int                    seed = 32'h87b2;
  logic [14:0]           hzs = 15'b010_1110_1010_0111;
  logic [3:0]            pts [15] = '{4'h0, 4'h3, 4'hb, 4'h0, 4'h4, 4'h4,
                                     4'h0, 4'h8, 4'h0, 4'h0, 4'h1, 4'h4,
                                     4'h2, 4'h2, 4'h0};
  logic [9:0]            es [15] = '{10'h200, 10'h230, 10'h238, 10'h000,
                                     10'h040, 10'h140, 10'h000, 10'h180,
                                     10'h000, 10'h200, 10'h201, 10'h204,
                                     10'h002, 10'h120, 10'h000};

  always #12.5 clk = ~clk;

  hszc_cnt_model hszc_cnt_model_inst (
    .i_clk_sys (clk),
    .i_load    (load),
    .i_value   (val),
    .i_step    (step),
    .o_count   (cnt)
  );

  hszc_top hszc_top_inst (
    .i_clk_sys       (clk),
    .i_reset_n       (rst_n),
    .i_ce            (ce),
    .i_reduced_strap (strap),
    .i_scan_end      (scan),
    .i_sw_en         (sw_en),
    .i_sw_counter    (sw_id),
    .i_sw_count      (cnt[5:0]),
    .i_sw_lower      (sw_lo),
    .i_sw_upper      (sw_hi),
    .i_sw_kind       (sw_kind),
    .i_hw_zone_req   (hz_req),
    .i_hw_count      (cnt[7:6]),
    .i_hw_lower      ({2{32'hffffffce}}),
    .i_hw_upper      ({2{32'h32}}),
    .i_hw_kind       (4'h0),
    .i_point_req     (pt_req),
    .o_res           (res),
    .o_bound_err     (berr),
    .o_sw_cnt_err    (cerr),
    .o_zone_grant    (zg),
    .o_zone_err      (ze),
    .o_point_grant   (pg),
    .o_point_err     (pe),
    .o_reduced       (red)
  );

  // ----------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------
  function automatic logic [2:0] zone(input int cv, input int l,
                                      input int h);
    if (cv <= l) return 3'h1;
    if (cv <= h) return 3'h2;
    return 3'h4;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Slow class holds its last value until the scan pulse
  always @(posedge clk) begin
    if (!rst_n) begin
      exp_res = '0;
      exp_berr = '0;
      exp_cerr = '0;
    end else if (ce) begin
      for (int s = 0; s < 6; s++) begin
        lo = sw_lo[s];
        hi = sw_hi[s];
        c = cnt[s];
        exp_berr[s] = sw_en[s] && lo > hi;
        exp_cerr[s] = sw_en[s] && strap && sw_id[s] == 4'h0;
        if (!sw_en[s] || exp_berr[s] || exp_cerr[s])
          exp_res[s] = 3'h0;
        else if (sw_kind[s] != 2'h2 || scan)
          exp_res[s] = zone(c, lo, hi);
      end
    end
  end

  always @(negedge clk) begin
    if (chk) begin
      check(32'(res[5:0]), 32'(exp_res));
      check(32'(berr[5:0]), 32'(exp_berr));
      check(32'(cerr), 32'(exp_cerr));
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------
  task automatic alloc(input int g, input int k);
    @(posedge clk);
    hz_req[g] <= hzs[k];
    pt_req[g] <= pts[k];
    @(posedge clk);
    @(negedge clk);
    check(32'({zg[g], ze[g], pg[g], pe[g]}), 32'(es[k]));
    if (k == 0) begin
      @(negedge clk);
      check(32'(res[6 + g]), 32'(zone(cnt[6 + g], -50, 50)));
    end
  endtask

  task automatic resync(input logic v);
    @(posedge clk);
    chk <= 1'b0;
    strap <= v;
    repeat (6) @(posedge clk);
    chk <= 1'b1;
    @(negedge clk);
    check(32'(red), 32'(v));
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sw_en <= 6'h3f;
    sw_hi[3] <= 32'hffffffce;
    // Counter 0 is legal on the full variant
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      load <= (i % 40 == 0);
      val <= (i % 80 == 0) ? -50 : (i % 80 == 40) ? 50 : $random(seed) % 300;
      step <= (i % 40 < 3) ? 0 : $random(seed) % 16;
      scan <= (i % 7 == 0);
      sw_en <= (i % 25 < 3) ? 6'h15 : 6'h3f;
      ce <= !(i % 50 >= 10 && i % 50 < 13);
      rst_n <= !(i == 150 || i == 151);
      sw_lo[2] <= (i >= 100 && i < 110) ? 60 : -50;
      sw_lo[4] <= (i >= 100 && i < 110) ? 60 : -50;
    end
    @(posedge clk);
    step <= 32'h0;
    scan <= 1'b0;
    ce <= 1'b1;
    rst_n <= 1'b1;
    $display("test zone sweep done");
    resync(1'b1);
    repeat (20) @(posedge clk);
    $display("test reduced counter done");
    resync(1'b0);
    for (int g = 0; g < 2; g++)
      for (int k = 0; k < 9; k++)
        alloc(g, k);
    resync(1'b1);
    for (int g = 0; g < 2; g++)
      for (int k = 9; k < 15; k++)
        alloc(g, k);
    $display("test allocation done");
    print_verdict();
  end
endmodule

`default_nettype wire
